//--- rtl/eet_pkg.sv
package eet_pkg;
	// bus geometry
	localparam int          EET_AW          = 8;
	localparam int          EET_DW          = 32;
	// register byte addresses
	localparam logic [7:0]  EET_A_COUNT     = 8'h00;
	localparam logic [7:0]  EET_A_MATCH1    = 8'h04;
	localparam logic [7:0]  EET_A_MATCH2    = 8'h08;
	localparam logic [7:0]  EET_A_FLAGCTL   = 8'h0C;
	localparam logic [7:0]  EET_A_MODE      = 8'h10;
	localparam logic [7:0]  EET_A_IRQ_STAT  = 8'h14;
	localparam logic [7:0]  EET_A_IRQ_CLR   = 8'h18;
	localparam logic [7:0]  EET_A_IRQ_EN    = 8'h1C;
	localparam logic [7:0]  EET_A_LAST      = 8'h1C;
	// flag/output control register fields
	localparam int          EET_F_MATCH2    = 7;
	localparam int          EET_F_MATCH1    = 6;
	localparam int          EET_F_WRAP      = 5;
	localparam int          EET_F_RSVD      = 4;
	localparam int          EET_F_OS2_LO    = 2;
	localparam int          EET_F_OS1_LO    = 0;
	localparam logic [7:0]  EET_FLAGCTL_RST = 8'h10;
	// mode register fields
	localparam int          EET_M_CLK_LO    = 0;
	localparam int          EET_M_EXTE_LO   = 3;
	localparam int          EET_M_CLR_LO    = 5;
	localparam int          EET_M_TRGE      = 7;
	localparam int          EET_M_TEDG_LO   = 8;
	localparam int          EET_MODE_W      = 10;
	localparam logic [9:0]  EET_MODE_RST    = 10'h000;
	// interrupt bit positions, shared by status, clear and enable
	localparam int          EET_I_WRAP      = 0;
	localparam int          EET_I_MATCH1    = 1;
	localparam int          EET_I_MATCH2    = 2;
	localparam int          EET_I_W         = 3;
	// clock selection codes: 1..6 are phi/128 down to phi/4
	localparam logic [2:0]  EET_CLK_STOP    = 3'h0;
	localparam logic [2:0]  EET_CLK_EXT     = 3'h7;
	localparam logic [3:0]  EET_DIV_EXP_TOP = 4'h8;
	localparam int          EET_DIV_W       = 7;
	// clear selection codes
	localparam logic [1:0]  EET_CLR_NONE    = 2'h0;
	localparam logic [1:0]  EET_CLR_M1      = 2'h1;
	localparam logic [1:0]  EET_CLR_M2      = 2'h2;
	localparam logic [1:0]  EET_CLR_PIN     = 2'h3;
	// output select codes
	localparam logic [1:0]  EET_OS_KEEP     = 2'h0;
	localparam logic [1:0]  EET_OS_LOW      = 2'h1;
	localparam logic [1:0]  EET_OS_HIGH     = 2'h2;
	localparam logic [1:0]  EET_OS_TOGGLE   = 2'h3;
	// edge selection codes
	localparam logic [1:0]  EET_EDGE_RISE   = 2'h0;
	localparam logic [1:0]  EET_EDGE_FALL   = 2'h1;
	localparam logic [7:0]  EET_COUNT_MAX   = 8'hFF;
	localparam logic [1:0]  EET_RESP_OKAY   = 2'h0;
	localparam logic [1:0]  EET_RESP_SLVERR = 2'h2;

	typedef enum logic {EET_RUN, EET_HALT} eet_run_t;

	// word aligned and inside the map
	function automatic logic eet_addr_ok(input logic [7:0] a);
		eet_addr_ok = (a[1:0] == 2'h0) && (a <= EET_A_LAST);
	endfunction
endpackage

//--- rtl/eet_pin_sync.sv
`timescale 1ns/1ps
module eet_pin_sync
	import eet_pkg::*;
(
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic pin_in,
	output logic      rise_out,
	output logic      fall_out
);
	logic meta_r;
	logic sync_r;
	logic prev_r;

	// two stages before any logic, then one for edge history
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
		end
		else
		begin
			meta_r <= pin_in;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	// edges come from the second and third stages only
	assign rise_out = sync_r & ~prev_r;
	assign fall_out = ~sync_r & prev_r;
endmodule

//--- rtl/eet_axil_slave.sv
`timescale 1ns/1ps
module eet_axil_slave
	import eet_pkg::*;
(
	input  wire logic          clk_in,
	input  wire logic          rst_n_in,
	input  wire logic [7:0]    awaddr_in,
	input  wire logic          awvalid_in,
	output logic               awready_out,
	input  wire logic [31:0]   wdata_in,
	input  wire logic [3:0]    wstrb_in,
	input  wire logic          wvalid_in,
	output logic               wready_out,
	output logic [1:0]         bresp_out,
	output logic               bvalid_out,
	input  wire logic          bready_in,
	input  wire logic [7:0]    araddr_in,
	input  wire logic          arvalid_in,
	output logic               arready_out,
	output logic [31:0]        rdata_out,
	output logic [1:0]         rresp_out,
	output logic               rvalid_out,
	input  wire logic          rready_in,
	output logic               wr_en_out,
	output logic [7:0]         wr_addr_out,
	output logic [31:0]        wr_data_out,
	output logic [3:0]         wr_strb_out,
	output logic               rd_en_out,
	output logic [7:0]         rd_addr_out,
	input  wire logic [31:0]   rd_data_in
);
	logic aw_held_r;
	logic w_held_r;
	wire  aw_hs = awvalid_in & awready_out;
	wire  w_hs  = wvalid_in & wready_out;
	wire  ar_hs = arvalid_in & arready_out;
	wire  wr_go = aw_held_r & w_held_r & ~bvalid_out;

	// write path: address and data taken in either order, one write at a time
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			awready_out <= 1'b1;
			wready_out  <= 1'b1;
			aw_held_r   <= 1'b0;
			w_held_r    <= 1'b0;
			bvalid_out  <= 1'b0;
			bresp_out   <= EET_RESP_OKAY;
			wr_en_out   <= 1'b0;
			wr_addr_out <= 8'h00;
			wr_data_out <= 32'h0000_0000;
			wr_strb_out <= 4'h0;
		end
		else
		begin
			wr_en_out <= wr_go;
			if (aw_hs)
			begin
				aw_held_r   <= 1'b1;
				awready_out <= 1'b0;
				wr_addr_out <= awaddr_in;
			end
			if (w_hs)
			begin
				w_held_r    <= 1'b1;
				wready_out  <= 1'b0;
				wr_data_out <= wdata_in;
				wr_strb_out <= wstrb_in;
			end
			if (wr_go)
			begin
				aw_held_r  <= 1'b0;
				w_held_r   <= 1'b0;
				bvalid_out <= 1'b1;
				bresp_out  <= eet_addr_ok(wr_addr_out) ? EET_RESP_OKAY : EET_RESP_SLVERR;
			end
			if (bvalid_out && bready_in)
			begin
				bvalid_out  <= 1'b0;
				awready_out <= 1'b1;
				wready_out  <= 1'b1;
			end
		end
	end

	// read path: data sampled at the address handshake, so side effects match
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			arready_out <= 1'b1;
			rvalid_out  <= 1'b0;
			rdata_out   <= 32'h0000_0000;
			rresp_out   <= EET_RESP_OKAY;
		end
		else if (ar_hs)
		begin
			arready_out <= 1'b0;
			rvalid_out  <= 1'b1;
			rdata_out   <= rd_data_in;
			rresp_out   <= eet_addr_ok(araddr_in) ? EET_RESP_OKAY : EET_RESP_SLVERR;
		end
		else if (rvalid_out && rready_in)
		begin
			rvalid_out  <= 1'b0;
			arready_out <= 1'b1;
		end
	end

	assign rd_en_out   = ar_hs;
	assign rd_addr_out = araddr_in;
endmodule

//--- rtl/eet_timer.sv
`timescale 1ns/1ps
module eet_timer
	import eet_pkg::*;
(
	input  wire logic          clk_in,
	input  wire logic          rst_n_in,
	input  wire logic [7:0]    s_axi_awaddr_in,
	input  wire logic          s_axi_awvalid_in,
	output logic               s_axi_awready_out,
	input  wire logic [31:0]   s_axi_wdata_in,
	input  wire logic [3:0]    s_axi_wstrb_in,
	input  wire logic          s_axi_wvalid_in,
	output logic               s_axi_wready_out,
	output logic [1:0]         s_axi_bresp_out,
	output logic               s_axi_bvalid_out,
	input  wire logic          s_axi_bready_in,
	input  wire logic [7:0]    s_axi_araddr_in,
	input  wire logic          s_axi_arvalid_in,
	output logic               s_axi_arready_out,
	output logic [31:0]        s_axi_rdata_out,
	output logic [1:0]         s_axi_rresp_out,
	output logic               s_axi_rvalid_out,
	input  wire logic          s_axi_rready_in,
	input  wire logic          ext_clk_pin_in,
	input  wire logic          ext_reset_pin_in,
	input  wire logic          trigger_in_pin_in,
	output logic               pulse_out_pin_out,
	output logic               irq_out
);
	// pin edge positions in the sync arrays
	localparam int PIN_CLK = 0;
	localparam int PIN_RST = 1;
	localparam int PIN_TRG = 2;
	localparam int PIN_N   = 3;

	logic                  wr_en;
	logic [7:0]            wr_addr;
	logic [31:0]           wr_data;
	logic [3:0]            wr_strb;
	logic                  rd_en;
	logic [7:0]            rd_addr;
	logic [31:0]           rd_data;
	logic [PIN_N-1:0]      pin_raw;
	logic [PIN_N-1:0]      pin_rise;
	logic [PIN_N-1:0]      pin_fall;

	logic [7:0]            count_value_r;
	logic [7:0]            count_value_nxt;
	logic [7:0]            match_reg_first_r;
	logic [7:0]            match_reg_second_r;
	logic                  match_first_flag_r;
	logic                  match_second_flag_r;
	logic                  wrap_flag_r;
	logic [2:0]            armed_r;
	logic [1:0]            out_sel_second_r;
	logic [1:0]            out_sel_first_r;
	logic [EET_MODE_W-1:0] mode_r;
	logic [EET_I_W-1:0]    irq_stat_r;
	logic [EET_I_W-1:0]    irq_en_r;
	logic [EET_DIV_W-1:0]  div_r;
	eet_run_t              run_r;
	eet_run_t              run_nxt;
	logic                  pulse_r;
	logic                  pulse_nxt;
	logic                  irq_r;

	// byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge_strb(input logic [31:0] cur,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		merge_strb = (cur & ~m) | (nw & m);
	endfunction

	// edge choice shared by the external clock and the trigger
	function automatic logic edge_hit(input logic [1:0] sel, input logic r,
		input logic f);
		if (sel == EET_EDGE_RISE)
			edge_hit = r;
		else if (sel == EET_EDGE_FALL)
			edge_hit = f;
		else
			edge_hit = r | f;
	endfunction

	// output pin reaction to one match event
	function automatic logic out_action(input logic [1:0] sel, input logic cur);
		unique case (sel)
			EET_OS_KEEP:   out_action = cur;
			EET_OS_LOW:    out_action = 1'b0;
			EET_OS_HIGH:   out_action = 1'b1;
			EET_OS_TOGGLE: out_action = ~cur;
		endcase
	endfunction

	eet_axil_slave u_bus (
		.clk_in      (clk_in),
		.rst_n_in    (rst_n_in),
		.awaddr_in   (s_axi_awaddr_in),
		.awvalid_in  (s_axi_awvalid_in),
		.awready_out (s_axi_awready_out),
		.wdata_in    (s_axi_wdata_in),
		.wstrb_in    (s_axi_wstrb_in),
		.wvalid_in   (s_axi_wvalid_in),
		.wready_out  (s_axi_wready_out),
		.bresp_out   (s_axi_bresp_out),
		.bvalid_out  (s_axi_bvalid_out),
		.bready_in   (s_axi_bready_in),
		.araddr_in   (s_axi_araddr_in),
		.arvalid_in  (s_axi_arvalid_in),
		.arready_out (s_axi_arready_out),
		.rdata_out   (s_axi_rdata_out),
		.rresp_out   (s_axi_rresp_out),
		.rvalid_out  (s_axi_rvalid_out),
		.rready_in   (s_axi_rready_in),
		.wr_en_out   (wr_en),
		.wr_addr_out (wr_addr),
		.wr_data_out (wr_data),
		.wr_strb_out (wr_strb),
		.rd_en_out   (rd_en),
		.rd_addr_out (rd_addr),
		.rd_data_in  (rd_data)
	);

	// all three pins are asynchronous to clk_in
	assign pin_raw = {trigger_in_pin_in, ext_reset_pin_in, ext_clk_pin_in};

	genvar gi;
	generate
		for (gi = 0; gi < PIN_N; gi++)
		begin : g_pin
			eet_pin_sync u_sync (
				.clk_in   (clk_in),
				.rst_n_in (rst_n_in),
				.pin_in   (pin_raw[gi]),
				.rise_out (pin_rise[gi]),
				.fall_out (pin_fall[gi])
			);
		end
	endgenerate

	// mode field views
	wire [2:0] clk_sel   = mode_r[EET_M_CLK_LO +: 3];
	wire [1:0] ext_edge  = mode_r[EET_M_EXTE_LO +: 2];
	wire [1:0] clr_sel   = mode_r[EET_M_CLR_LO +: 2];
	wire       trg_en    = mode_r[EET_M_TRGE];
	wire [1:0] trg_edge  = mode_r[EET_M_TEDG_LO +: 2];

	// register write decode
	wire wr_count   = wr_en && (wr_addr == EET_A_COUNT);
	wire wr_match1  = wr_en && (wr_addr == EET_A_MATCH1);
	wire wr_match2  = wr_en && (wr_addr == EET_A_MATCH2);
	wire wr_flagctl = wr_en && (wr_addr == EET_A_FLAGCTL) && wr_strb[0];
	wire wr_mode    = wr_en && (wr_addr == EET_A_MODE);
	wire wr_iclr    = wr_en && (wr_addr == EET_A_IRQ_CLR) && wr_strb[0];
	wire wr_ien     = wr_en && (wr_addr == EET_A_IRQ_EN);
	wire rd_flagctl = rd_en && (rd_addr == EET_A_FLAGCTL);
	wire [31:0] wr_merged_mode = merge_strb({22'h0, mode_r}, wr_data, wr_strb);
	wire [31:0] wr_merged_cnt  = merge_strb({24'h0, count_value_r}, wr_data, wr_strb);
	wire [31:0] wr_merged_m1   = merge_strb({24'h0, match_reg_first_r}, wr_data, wr_strb);
	wire [31:0] wr_merged_m2   = merge_strb({24'h0, match_reg_second_r}, wr_data, wr_strb);
	wire [31:0] wr_merged_ien  = merge_strb({29'h0, irq_en_r}, wr_data, wr_strb);

	// internal rate picks how many low prescaler bits must be all ones
	wire [3:0]            div_exp  = EET_DIV_EXP_TOP - {1'b0, clk_sel};
	wire [EET_DIV_W-1:0]  div_mask = EET_DIV_W'((8'h01 << div_exp) - 8'h01);
	wire int_tick = ((div_r & div_mask) == div_mask);
	wire ext_tick = edge_hit(ext_edge, pin_rise[PIN_CLK], pin_fall[PIN_CLK]);
	// a chosen clock source advances the count on each of its events
	wire src_tick = (clk_sel == EET_CLK_EXT) ? ext_tick :
		((clk_sel == EET_CLK_STOP) ? 1'b0 : int_tick);
	// a halted counter ignores its clock until the trigger
	wire tick = src_tick && (run_r == EET_RUN);

	// match fires in the last equal state, as the count moves on
	wire match1_evt = tick && (count_value_r == match_reg_first_r);
	wire match2_evt = tick && (count_value_r == match_reg_second_r);
	wire pin_clr = (clr_sel == EET_CLR_PIN) && pin_rise[PIN_RST];
	wire clr_evt = ((clr_sel == EET_CLR_M1) && match1_evt) ||
		((clr_sel == EET_CLR_M2) && match2_evt) || pin_clr;
	// wrap on any FF tick that a clear does not take, even one that a count write overrides
	wire wrap_evt = tick && (count_value_r == EET_COUNT_MAX) && !clr_evt;
	// trigger edge resumes a counter halted by its clear
	wire trg_evt  = edge_hit(trg_edge, pin_rise[PIN_TRG], pin_fall[PIN_TRG]);

	// eight bit counter; software write overrides the count
	always_comb
	begin
		count_value_nxt = count_value_r;
		if (wr_count)
			count_value_nxt = wr_merged_cnt[7:0];
		else if (clr_evt)
			count_value_nxt = 8'h00;
		else if (tick)
			count_value_nxt = count_value_r + 8'h01;
	end

	// count stop halts on clear; trigger restarts it
	always_comb
	begin
		run_nxt = run_r;
		unique case (run_r)
			EET_RUN:
				if (trg_en && clr_evt)
					run_nxt = EET_HALT;
			EET_HALT:
				if (!trg_en || trg_evt)
					run_nxt = EET_RUN;
		endcase
	end

	// two independent match events shape the pulse; in a tie the second acts on the first's result
	always_comb
	begin
		pulse_nxt = pulse_r;
		// first match uses the low select pair
		if (match1_evt)
			pulse_nxt = out_action(out_sel_first_r, pulse_nxt);
		// second match uses the high select pair
		if (match2_evt)
			pulse_nxt = out_action(out_sel_second_r, pulse_nxt);
	end

	// prescaler runs free so internal rates stay phase locked to each other
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			div_r <= '0;
		else
			div_r <= div_r + EET_DIV_W'(1);
	end

	// counter, run state and pulse pin
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			count_value_r <= 8'h00;
			run_r         <= EET_RUN;
			pulse_r       <= 1'b0;
		end
		else
		begin
			count_value_r <= count_value_nxt;
			run_r         <= run_nxt;
			// delay from trigger is set by the match values
			pulse_r       <= pulse_nxt;
		end
	end

	// software-owned configuration registers
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			match_reg_first_r  <= 8'h00;
			match_reg_second_r <= 8'h00;
			mode_r             <= EET_MODE_RST;
			irq_en_r           <= '0;
			out_sel_second_r   <= EET_FLAGCTL_RST[EET_F_OS2_LO +: 2];
			out_sel_first_r    <= EET_FLAGCTL_RST[EET_F_OS1_LO +: 2];
		end
		else
		begin
			if (wr_match1)
				match_reg_first_r <= wr_merged_m1[7:0];
			if (wr_match2)
				match_reg_second_r <= wr_merged_m2[7:0];
			if (wr_mode)
				mode_r <= wr_merged_mode[EET_MODE_W-1:0];
			if (wr_ien)
				irq_en_r <= wr_merged_ien[EET_I_W-1:0];
			if (wr_flagctl)
			begin
				out_sel_second_r <= wr_data[EET_F_OS2_LO +: 2];
				out_sel_first_r  <= wr_data[EET_F_OS1_LO +: 2];
			end
		end
	end

	// flag clear qualifiers: armed by a read of one, consumed by a write of zero
	wire clr_m2   = wr_flagctl && armed_r[2] && !wr_data[EET_F_MATCH2];
	wire clr_m1   = wr_flagctl && armed_r[1] && !wr_data[EET_F_MATCH1];
	wire clr_wrap = wr_flagctl && armed_r[0] && !wr_data[EET_F_WRAP];

	// status flags; a hardware set in the clearing cycle wins
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			match_second_flag_r <= 1'b0;
			match_first_flag_r  <= 1'b0;
			wrap_flag_r         <= 1'b0;
			armed_r             <= 3'h0;
		end
		else
		begin
			match_second_flag_r <= match2_evt | (match_second_flag_r & ~clr_m2);
			match_first_flag_r  <= match1_evt | (match_first_flag_r & ~clr_m1);
			wrap_flag_r         <= wrap_evt | (wrap_flag_r & ~clr_wrap);
			// reading one arms; a write to the register's low byte disarms
			if (rd_flagctl)
				armed_r <= armed_r |
					{match_second_flag_r, match_first_flag_r, wrap_flag_r};
			else if (wr_flagctl)
				armed_r <= 3'h0;
		end
	end

	// sticky interrupt status from the three sources
	wire [EET_I_W-1:0] irq_set = {match2_evt, match1_evt, wrap_evt};
	wire [EET_I_W-1:0] irq_clr = wr_iclr ? wr_data[EET_I_W-1:0] : '0;

	// interrupt status and the level output; set beats clear
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			irq_stat_r <= '0;
			irq_r      <= 1'b0;
		end
		else
		begin
			irq_stat_r <= irq_set | (irq_stat_r & ~irq_clr);
			// wrap request gated by its enable
			// match requests gated by their enables
			irq_r      <= |(irq_stat_r & irq_en_r);
		end
	end

	wire [7:0] flagctl_view = {match_second_flag_r, match_first_flag_r,
		wrap_flag_r, 1'b1, out_sel_second_r, out_sel_first_r};

	// read mux; unmapped and write-only addresses read zero
	assign rd_data =
		(rd_addr == EET_A_COUNT)    ? {24'h0, count_value_r} :
		(rd_addr == EET_A_MATCH1)   ? {24'h0, match_reg_first_r} :
		(rd_addr == EET_A_MATCH2)   ? {24'h0, match_reg_second_r} :
		(rd_addr == EET_A_FLAGCTL)  ? {24'h0, flagctl_view} :
		(rd_addr == EET_A_MODE)     ? {22'h0, mode_r} :
		(rd_addr == EET_A_IRQ_STAT) ? {29'h0, irq_stat_r} :
		(rd_addr == EET_A_IRQ_EN)   ? {29'h0, irq_en_r} : 32'h0000_0000;

	assign pulse_out_pin_out = pulse_r;
	assign irq_out           = irq_r;
endmodule

//--- tb/eet_pin_model.sv
`timescale 1ns/1ps
module eet_pin_model (
	input  wire logic clk_in,
	output logic      clk_pin_out,
	output logic      rst_pin_out,
	output logic      trig_pin_out
);
	logic [2:0] pin_r = 3'h0;
	// pins rest low between commanded pulses
	assign clk_pin_out  = pin_r[0];
	assign rst_pin_out  = pin_r[1];
	assign trig_pin_out = pin_r[2];
	// each level held four edges, wider than the 2-flop sync
	task automatic pulse(input int k, input int n);
		repeat (n)
		begin
			repeat (4) @(posedge clk_in);
			pin_r[k] <= 1'b1;
			repeat (4) @(posedge clk_in);
			pin_r[k] <= 1'b0;
		end
		repeat (4) @(posedge clk_in);
	endtask
endmodule

//--- tb/eet_timer_monitor.sv
`timescale 1ns/1ps
module eet_timer_monitor
	import eet_pkg::*;
(
	input wire logic        clk_in,
	input wire logic        rst_n_in,
	input wire logic        s_axi_awvalid_in,
	input wire logic        s_axi_awready_out,
	input wire logic        s_axi_wvalid_in,
	input wire logic        s_axi_wready_out,
	input wire logic [1:0]  s_axi_bresp_out,
	input wire logic        s_axi_bvalid_out,
	input wire logic        s_axi_bready_in,
	input wire logic [7:0]  s_axi_araddr_in,
	input wire logic        s_axi_arvalid_in,
	input wire logic        s_axi_arready_out,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic [1:0]  s_axi_rresp_out,
	input wire logic        s_axi_rvalid_out,
	input wire logic        s_axi_rready_in
);
	logic [7:0] ra_r;
	// keep the read address until its data returns
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			ra_r <= 8'h00;
		else if (s_axi_arvalid_in && s_axi_arready_out)
			ra_r <= s_axi_araddr_in;
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	a_b_stands: assert property (
		s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
		else $error("write response dropped");
	a_r_stands: assert property (
		s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
		else $error("read data dropped");
	a_read_answer: assert property (
		s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
		else $error("read answer late");
	a_write_answer: assert property (
		s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
		|-> ##2 s_axi_bvalid_out) else $error("write answer late");
	a_aw_refused: assert property (
		s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
		else $error("write taken while busy");
	a_ar_refused: assert property (
		s_axi_rvalid_out |-> !s_axi_arready_out) else $error("read taken while busy");
	a_rsvd_one: assert property (
		s_axi_rvalid_out && ra_r == EET_A_FLAGCTL |-> s_axi_rdata_out[4])
		else $error("reserved bit reads zero");
	a_bad_addr: assert property (
		s_axi_rvalid_out && ra_r > EET_A_LAST |-> s_axi_rresp_out == EET_RESP_SLVERR)
		else $error("unmapped read not refused");
endmodule
bind eet_timer eet_timer_monitor MON (.*);

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import eet_pkg::*;
;
	logic        clk_in, rst_n_in, irq_out, pulse_out_pin_out;
	logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in;
	logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rdat;
	logic [3:0]  s_axi_wstrb_in;
	logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, rrsp;
	logic        s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out;
	logic        s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out;
	logic        s_axi_rvalid_out, s_axi_rready_in;
	logic        ext_clk_pin_in, ext_reset_pin_in, trigger_in_pin_in;
	int          miscompares = 0;
	int          tests_run = 0;
	eet_timer DUT (.*);
	eet_pin_model PIN (.clk_in(clk_in), .clk_pin_out(ext_clk_pin_in),
		.rst_pin_out(ext_reset_pin_in), .trig_pin_out(trigger_in_pin_in));
	// 250 MHz
	initial
	begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// a used-up wait counts as a mismatch and ends the run
	task automatic tmo(input bit bad);
		if (bad)
		begin
			miscompares++;
			end_of_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_in);
		s_axi_awaddr_in  <= a;
		s_axi_wdata_in   <= d;
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in  <= 1'b1;
		s_axi_bready_in  <= 1'b1;
		do
		begin
			@(posedge clk_in);
			n++;
			if (s_axi_awready_out)
				s_axi_awvalid_in <= 1'b0;
			if (s_axi_wready_out)
				s_axi_wvalid_in <= 1'b0;
		end
		while (!s_axi_bvalid_out && n < 200);
		s_axi_bready_in <= 1'b0;
		tmo(n >= 200);
		chk(32'(s_axi_bresp_out), 32'(EET_RESP_OKAY));
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge clk_in);
		s_axi_araddr_in  <= a;
		s_axi_arvalid_in <= 1'b1;
		s_axi_rready_in  <= 1'b1;
		do
		begin
			@(posedge clk_in);
			n++;
			if (s_axi_arready_out)
				s_axi_arvalid_in <= 1'b0;
		end
		while (!s_axi_rvalid_out && n < 200);
		rdat = s_axi_rdata_out;
		rrsp = s_axi_rresp_out;
		s_axi_rready_in <= 1'b0;
		tmo(n >= 200);
	endtask
	// status clears land first, then wait for the level interrupt
	task automatic wirq;
		int n;
		n = 0;
		repeat (2) @(posedge clk_in);
		while (irq_out !== 1'b1 && n < 600)
		begin
			@(posedge clk_in);
			n++;
		end
		tmo(n >= 600);
	endtask
	task automatic t_reset;
		rd(EET_A_FLAGCTL);
		chk(rdat, 32'h00000010);
		rd(EET_A_COUNT);
		chk(rdat, 32'h00000000);
		rd(8'h20);
		chk(32'(rrsp), 32'(EET_RESP_SLVERR));
		$display("t_reset done");
	endtask
	task automatic t_ext;
		wr(EET_A_MODE, 32'h00000007);
		PIN.pulse(0, 3);
		rd(EET_A_COUNT);
		chk(rdat, 32'h00000003);
		// both edges selected: two pulses give four counts
		wr(EET_A_MODE, 32'h00000017);
		PIN.pulse(0, 2);
		rd(EET_A_COUNT);
		chk(rdat, 32'h00000007);
		wr(EET_A_MODE, 32'h00000060);
		wr(EET_A_COUNT, 32'h00000040);
		PIN.pulse(1, 1);
		rd(EET_A_COUNT);
		chk(rdat, 32'h00000000);
		$display("t_ext done");
	endtask
	task automatic t_match;
		wr(EET_A_MATCH1, 32'h00000005);
		wr(EET_A_FLAGCTL, 32'h00000003);
		// stale status from the external count would raise irq at once
		wr(EET_A_IRQ_CLR, 32'h00000007);
		wr(EET_A_IRQ_EN, 32'h00000002);
		wr(EET_A_COUNT, 32'h00000000);
		wr(EET_A_MODE, 32'h000000A6);
		wirq();
		chk(32'(pulse_out_pin_out), 32'h00000001);
		repeat (40) @(posedge clk_in);
		rd(EET_A_COUNT);
		chk(rdat, 32'h00000000);
		rd(EET_A_FLAGCTL);
		// second match register is zero, so its flag is set as well
		chk(rdat, 32'h000000D3);
		wr(EET_A_FLAGCTL, 32'h00000053);
		rd(EET_A_FLAGCTL);
		chk(rdat, 32'h00000053);
		wr(EET_A_FLAGCTL, 32'h00000013);
		rd(EET_A_FLAGCTL);
		chk(rdat, 32'h00000013);
		wr(EET_A_IRQ_CLR, 32'h00000002);
		repeat (2) @(posedge clk_in);
		chk(32'(irq_out), 32'h00000000);
		PIN.pulse(2, 1);
		wirq();
		chk(32'(pulse_out_pin_out), 32'h00000000);
		$display("t_match done");
	endtask
	task automatic t_wrap;
		wr(EET_A_MODE, 32'h00000006);
		wr(EET_A_IRQ_EN, 32'h00000000);
		wr(EET_A_IRQ_CLR, 32'h00000007);
		wr(EET_A_COUNT, 32'h000000FE);
		repeat (40) @(posedge clk_in);
		chk(32'(irq_out), 32'h00000000);
		wr(EET_A_IRQ_EN, 32'h00000001);
		repeat (2) @(posedge clk_in);
		chk(32'(irq_out), 32'h00000001);
		rd(EET_A_IRQ_STAT);
		chk(rdat & 32'h00000001, 32'h00000001);
		rd(EET_A_FLAGCTL);
		chk(rdat & 32'h00000020, 32'h00000020);
		$display("t_wrap done");
	endtask
	task automatic t_os2;
		logic [1:0] os [4];
		logic [3:0] ex;
		os = '{EET_OS_HIGH, EET_OS_LOW, EET_OS_TOGGLE, EET_OS_KEEP};
		ex = 4'hD;
		wr(EET_A_MODE, 32'h00000046);
		wr(EET_A_MATCH2, 32'h00000030);
		wr(EET_A_IRQ_EN, 32'h00000004);
		for (int i = 0; i < 4; i++)
		begin
			wr(EET_A_FLAGCTL, {28'h0000000, os[i], 2'h0});
			wr(EET_A_IRQ_CLR, 32'h00000007);
			wirq();
			chk(32'(pulse_out_pin_out), 32'(ex[i]));
		end
		rd(EET_A_FLAGCTL);
		chk(rdat & 32'h00000080, 32'h00000080);
		$display("t_os2 done");
	endtask
	// main sequence: reset held four cycles, then each scenario
	initial
	begin
		rst_n_in = 1'b0;
		{s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 3'h0;
		{s_axi_arvalid_in, s_axi_rready_in} = 2'h0;
		{s_axi_awaddr_in, s_axi_araddr_in} = 16'h0000;
		s_axi_wdata_in = 32'h00000000;
		s_axi_wstrb_in = 4'hF;
		repeat (4) @(posedge clk_in);
		rst_n_in <= 1'b1;
		t_reset();
		t_ext();
		t_match();
		t_wrap();
		t_os2();
		end_of_test();
	end
endmodule
